// ==== include/crksc_pkg.sv ====
// Purpose: shared constants and carriers for the crank sensor conditioner
// Assumes: 20 MHz system clock
// Notes: parameter registers are 8 bits, threshold high nibble, blank low
package crksc_pkg;
	localparam int PARAM_W = 8;
	localparam int CODE_W = 4;
	localparam int THR_MSB = 7;
	localparam int THR_LSB = 4;
	localparam int BLK_MSB = 3;
	localparam int BLK_LSB = 0;
	localparam logic [7:0] RUN_RESET = 8'h0050;
	localparam logic [7:0] CRANK_RESET = 8'h0000;
	localparam logic [3:0] THR_DEFAULT = 4'h0005;
	localparam logic [3:0] THR_MAX = 4'h000F;
	localparam int BLK_SHIFT = 5;
	localparam int WIDTH_W = 24;
	localparam int DIV_W = 8;

	typedef struct packed {
		logic [3:0] thrCode;
		logic [3:0] blankCode;
	} crksc_param_t;

	typedef enum logic [1:0] {
		CRKSC_IDLE,
		CRKSC_BLANK
	} crksc_state_t;
endpackage : crksc_pkg

// ==== rtl/crksc_conditioner.sv ====
// What this block does
// - Manual mode holds separate cranking and running threshold/blanking sets.
// - All-zero cranking register selects running register values.
// - Non-zero cranking register supplies threshold and blanking instead.
// - Threshold code is bits 7..4 of active register; default 0101.
// - Active threshold code drives converter output through one register stage.
// - One-shot blanking after each edge, in 1/32 steps of last high/low pulse.
// - Conditioned comparator result drives the conditioned output pin.
// - Optionally divide conditioned train onto tachometer output.
// - Automatic mode sets threshold from measured input amplitude.
//
// Purpose: digital side of crank reluctance sensor conditioning
// Assumes: comparator result and peak code arrive synchronous to clock
// Notes: blanking step is 1/32 of the reference pulse per code step
`timescale 1ns/1ps
module crksc_conditioner #(
	parameter int WIDTH_W = crksc_pkg::WIDTH_W,
	parameter int DIV_W = crksc_pkg::DIV_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Parameter sets from the controller
	input wire crksc_pkg::crksc_param_t runParams,
	input wire crksc_pkg::crksc_param_t crankParams,
	// Mode controls
	input wire logic autoMode,
	input wire logic useLowRef,
	input wire logic disableSensor,
	input wire logic tachoEnable,
	input wire logic [DIV_W-1:0] tachoRatio,
	// Analog front end
	input wire logic comparatorIn,
	input wire logic [3:0] peakCode,
	input wire logic zeroCross,
	output logic [3:0] thresholdCode,
	// Status
	output logic crankActive,
	output logic blanking,
	output logic [WIDTH_W-1:0] lastPulseWidth,
	// Pins
	output logic conditioned_pulse_out,
	output logic tacho_pulse_out
);
	typedef struct packed {
		crksc_pkg::crksc_state_t fsm;
		logic outLevel;
		logic [WIDTH_W-1:0] widthCount;
		logic [WIDTH_W-1:0] refWidth;
		logic [WIDTH_W-1:0] blankLeft;
		logic [3:0] thr;
		logic [3:0] autoThr;
		logic crankSel;
	} crksc_state_all_t;

	crksc_state_all_t st;
	crksc_state_all_t next_st;
	crksc_pkg::crksc_param_t active;
	logic [WIDTH_W+3:0] product;
	logic [WIDTH_W-1:0] blankLen;
	logic refLevel;

	// Parameter set selection
	always_comb begin
		if (crankParams != '0)
			active = crankParams;
		else
			active = runParams;
	end

	// Blank length = width * code / 32; zero code means no blanking
	assign product = st.refWidth * active.blankCode;
	assign blankLen = WIDTH_W'(product >> crksc_pkg::BLK_SHIFT);
	// Which level's duration feeds the blanking reference
	assign refLevel = !useLowRef;

	always_comb begin
		next_st = st;
		next_st.crankSel = (crankParams != '0);
		// Automatic threshold: jump to max at zero crossing, then settle
		// toward the measured peak; decay timing is not modelled.
		if (zeroCross)
			next_st.autoThr = crksc_pkg::THR_MAX;
		else if (st.autoThr > active.thrCode && st.autoThr > peakCode)
			next_st.autoThr = st.autoThr - 4'h0001;
		next_st.thr = autoMode ? st.autoThr : active.thrCode;
		if (st.widthCount != '1)
			next_st.widthCount = st.widthCount + WIDTH_W'(1);
		unique case (st.fsm)
			crksc_pkg::CRKSC_IDLE: begin
				if (!disableSensor && comparatorIn != st.outLevel) begin
					next_st.outLevel = comparatorIn;
					next_st.widthCount = WIDTH_W'(1);
					if (st.outLevel == refLevel)
						next_st.refWidth = st.widthCount;
					if (blankLen != '0) begin
						next_st.fsm = crksc_pkg::CRKSC_BLANK;
						next_st.blankLeft = blankLen;
					end
				end
			end
			crksc_pkg::CRKSC_BLANK: begin
				// Edges ignored while the one-shot runs
				if (st.blankLeft <= WIDTH_W'(1))
					next_st.fsm = crksc_pkg::CRKSC_IDLE;
				else
					next_st.blankLeft = st.blankLeft - WIDTH_W'(1);
			end
			default: next_st.fsm = crksc_pkg::CRKSC_IDLE;
		endcase
		if (disableSensor) begin
			next_st.outLevel = 1'b0;
			next_st.fsm = crksc_pkg::CRKSC_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st <= '0;
			st.fsm <= crksc_pkg::CRKSC_IDLE;
			st.thr <= crksc_pkg::THR_DEFAULT;
			st.autoThr <= crksc_pkg::THR_MAX;
		end else begin
			st <= next_st;
		end
	end

	// Tachometer divider
	crksc_tacho_div #(
		.DIV_W(DIV_W)
	) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.enable(tachoEnable),
		.ratio(tachoRatio),
		.pulseIn(st.outLevel),
		.pulseOut(tacho_pulse_out)
	);

	assign conditioned_pulse_out = st.outLevel;
	assign thresholdCode = st.thr;
	assign crankActive = st.crankSel;
	assign blanking = (st.fsm == crksc_pkg::CRKSC_BLANK);
	assign lastPulseWidth = st.refWidth;
endmodule : crksc_conditioner

// ==== rtl/crksc_tacho_div.sv ====
// Purpose: divides the conditioned pulse train for the tachometer pin
// Assumes: pulseIn synchronous to clock
// Notes: divide ratio 0 or 1 passes the train through
`timescale 1ns/1ps
module crksc_tacho_div #(
	parameter int DIV_W = crksc_pkg::DIV_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	input wire logic [DIV_W-1:0] ratio,
	// Pulse train
	input wire logic pulseIn,
	output logic pulseOut
);
	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic prevIn;
		logic out;
	} crksc_div_state_t;

	crksc_div_state_t st;
	crksc_div_state_t next_st;

	// Toggle out every ratio rising edges; output period is 2*ratio input
	always_comb begin
		next_st = st;
		next_st.prevIn = pulseIn;
		if (!enable) begin
			next_st.out = 1'b0;
			next_st.count = '0;
		end else if (ratio <= DIV_W'(1)) begin
			next_st.out = pulseIn;
		end else if (pulseIn && !st.prevIn) begin
			if (st.count >= ratio - DIV_W'(1)) begin
				next_st.count = '0;
				next_st.out = !st.out;
			end else begin
				next_st.count = st.count + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign pulseOut = st.out;
endmodule : crksc_tacho_div

// ==== test/crksc_conditioner_chk.sv ====
// Purpose: port checks for the conditioner
// Assumes: manual threshold mode, plus automatic maximum after zero crossing
// Notes: single clock domain
`timescale 1ns/1ps
module crksc_conditioner_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Watched ports
	input wire crksc_pkg::crksc_param_t runParams,
	input wire crksc_pkg::crksc_param_t crankParams,
	input wire logic autoMode,
	input wire logic zeroCross,
	input wire logic disableSensor,
	input wire logic tachoEnable,
	input wire logic comparatorIn,
	input wire logic [3:0] thresholdCode,
	input wire logic crankActive,
	input wire logic blanking,
	input wire logic conditioned_pulse_out,
	input wire logic tacho_pulse_out
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Parameter set selection, one cycle late
	crank_thr_a: assert property (
		!autoMode && crankParams != 0
		|=> thresholdCode == $past(crankParams.thrCode))
		else $error("crank code");
	run_thr_a: assert property (
		!autoMode && crankParams == 0
		|=> thresholdCode == $past(runParams.thrCode))
		else $error("run code");
	auto_max_a: assert property (
		zeroCross ##1 autoMode |=> thresholdCode == 4'hF)
		else $error("auto max");
	crank_flag_a: assert property (
		1'b1 |=> crankActive == ($past(crankParams) != 8'h00))
		else $error("crank flag");
	// Output follows an accepted edge
	out_follow_a: assert property (
		!blanking && !disableSensor && comparatorIn != conditioned_pulse_out
		|=> conditioned_pulse_out == $past(comparatorIn))
		else $error("no follow");
	blank_hold_a: assert property (
		blanking && !disableSensor ##1 blanking
		|-> $stable(conditioned_pulse_out))
		else $error("blank moved");
	blank_start_a: assert property (
		$rose(blanking) |-> $changed(conditioned_pulse_out))
		else $error("blank start");
	disable_a: assert property (
		disableSensor |=> !conditioned_pulse_out)
		else $error("disable");
	tacho_off_a: assert property (
		!tachoEnable |=> !tacho_pulse_out)
		else $error("tacho");
endmodule : crksc_conditioner_chk

bind crksc_conditioner crksc_conditioner_chk u_chk (.clock, .rst_n,
	.runParams, .crankParams, .autoMode, .zeroCross, .disableSensor,
	.tachoEnable, .comparatorIn,
	.thresholdCode, .crankActive, .blanking, .conditioned_pulse_out,
	.tacho_pulse_out);

// ==== test/crksc_mcu_model.sv ====
// Purpose: controller model writing both parameter sets
// Assumes: writes land at the falling edge
// Notes: cranking set forced non-zero until running
`timescale 1ns/1ps
module crksc_mcu_model (
	// Clock
	input wire logic clock,
	// Stimulus
	input wire logic running,
	input wire logic [7:0] rnd,
	// Parameter sets
	output crksc_pkg::crksc_param_t runParams,
	output crksc_pkg::crksc_param_t crankParams
);
	// Cleared cranking set hands over to running set
	initial {runParams, crankParams} = 16'h0000;
	always @(negedge clock) begin
		runParams <= rnd;
		crankParams <= running ? 8'h00 : {rnd[3:0], rnd[7:4]} | 8'h01;
	end
endmodule : crksc_mcu_model

// ==== test/testbench.sv ====
// Purpose: random bench for the crank sensor conditioner
// Assumes: manual and automatic mode mixed at random, automatic threshold inputs driven randomly
// Notes: expected codes come from the parameter sets seen
`timescale 1ns/1ps
module testbench;
	logic clock, rst_n, running, cmpIn, dis, tEn, useLow, crk, blk, out, tacho;
	logic [7:0] rnd, ratio;
	logic [3:0] thr, peak, want;
	logic [3:0] expAuto = 4'hF;
	logic [23:0] lpw;
	logic autoM, zc, expOut = 0, tPrev = 0, tOut = 0;
	crksc_pkg::crksc_param_t runP, crankP, act;
	int fails = 0, checksDone = 0, cycles = 0;
	int refW = 0, wcount = 0, oldW, left = 0, tCnt = 0, bl;
	crksc_mcu_model u_crksc_mcu_model (.clock(clock), .running(running),
		.rnd(rnd), .runParams(runP), .crankParams(crankP));
	crksc_conditioner u_crksc_conditioner (.clock(clock), .rst_n(rst_n),
		.runParams(runP), .crankParams(crankP), .autoMode(autoM),
		.useLowRef(useLow), .disableSensor(dis), .tachoEnable(tEn),
		.tachoRatio(ratio), .comparatorIn(cmpIn), .peakCode(peak),
		.zeroCross(zc), .thresholdCode(thr), .crankActive(crk),
		.blanking(blk), .lastPulseWidth(lpw), .conditioned_pulse_out(out),
		.tacho_pulse_out(tacho));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checksDone++;
		if (seen !== want) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic wrap_up();
		if (fails == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		clock = 0;
		forever #25 clock = ~clock;
	end
	// Slow comparator edges leave room for blanking
	always @(negedge clock) begin
		rnd <= lfsr(rnd);
		running <= rnd[7] & rnd[6];
		cmpIn <= cmpIn ^ (rnd[2:0] == 3'h0);
		dis <= rnd[5:1] == 5'h00;
		tEn <= rnd[4] | rnd[3];
		useLow <= rnd[6];
		ratio <= {6'h00, rnd[1:0]};
		autoM <= rnd[3] & rnd[0];
		zc <= rnd[7:5] == 3'h7;
		peak <= rnd[3:0];
	end
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		rnd = 8'h3E;
		ratio = 8'h00;
		{rst_n, running, cmpIn, dis, tEn, useLow, autoM, zc} = 8'h00;
		peak = 4'h0;
		repeat (12) @(negedge clock);
		check(thr, crksc_pkg::THR_DEFAULT);
		rst_n = 1;
		repeat (2000) begin
			@(posedge clock);
			// Reference model, fed by the inputs standing at this edge
			act = crankP != 0 ? crankP : runP;
			want = autoM ? expAuto : act.thrCode;
			if (zc)
				expAuto = crksc_pkg::THR_MAX;
			else if (expAuto > act.thrCode && expAuto > peak)
				expAuto = expAuto - 4'h1;
			// Divider sees the output level from before this edge
			if (!tEn) begin
				tOut = 0;
				tCnt = 0;
			end else if (ratio <= 8'h01) begin
				tOut = expOut;
			end else if (expOut && !tPrev) begin
				if (tCnt >= ratio - 1) begin
					tCnt = 0;
					tOut = !tOut;
				end else begin
					tCnt++;
				end
			end
			tPrev = expOut;
			bl = (refW * act.blankCode) >> crksc_pkg::BLK_SHIFT;
			oldW = wcount;
			if (wcount < 24'hFF_FFFF)
				wcount++;
			if (dis) begin
				expOut = 0;
				left = 0;
			end else if (left > 0) begin
				left--;
			end else if (cmpIn != expOut) begin
				if (expOut == !useLow)
					refW = oldW;
				expOut = cmpIn;
				wcount = 1;
				left = bl;
			end
			#1;
			check(thr, want);
			check(crk, crankP != 0);
			check(out, expOut);
			check(blk, left != 0);
			check(lpw, refW);
			check(tacho, tOut);
		end
		wrap_up();
	end
endmodule : testbench
